//--- verilog/scr_pkg.sv
// Constants, field layout and pin-drive decoding for the serial configuration port.
// Assumes one 40 MHz system clock; serial pins are asynchronous to it.
package scr_pkg;

  // ****************************************
  // Word layout
  // ****************************************
  localparam int unsigned WORD_W = 32;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 27;
  localparam int unsigned PIN_COUNT = 3;
  localparam int unsigned STATUS_PINS = 4;
  localparam int unsigned PAIR_COUNT = 5;
  localparam int unsigned DAC_W = 10;
  localparam logic [4:0] LAST_BIT = 5'h1A;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [4:0] ADDR_PAIR01 = 5'h00;
  localparam logic [4:0] ADDR_PINS_LOCK = 5'h0C;
  localparam logic [4:0] ADDR_PINS_HOLD = 5'h0D;
  localparam logic [4:0] ADDR_PINS_IN1 = 5'h0E;
  localparam logic [4:0] ADDR_DAC = 5'h17;
  localparam logic [4:0] ADDR_READBACK = 5'h1F;

  // ****************************************
  // Field positions within the 27 data bits
  // ****************************************
  localparam int unsigned SOFT_RESET_POS = 12;
  localparam int unsigned LOCK_MUX_POS = 22;
  localparam int unsigned LOCK_TYPE_POS = 19;
  localparam int unsigned LATCH_RD_POS = 16;
  localparam int unsigned HOLD_MUX_POS = 22;
  localparam int unsigned HOLD_TYPE_POS = 19;
  localparam int unsigned IN1_MUX_POS = 15;
  localparam int unsigned IN0_TYPE_POS = 11;
  localparam int unsigned IN0_MUX_POS = 7;
  localparam int unsigned IN1_TYPE_POS = 19;
  localparam int unsigned RB_ADDR_POS = 11;
  localparam int unsigned RB_LATCH_POS = 16;
  localparam int unsigned DAC_POS = 0;

  // ****************************************
  // Pin source and output type codes
  // ****************************************
  localparam logic [4:0] SRC_LOW = 5'h00;
  localparam logic [4:0] SRC_READBACK = 5'h06;
  localparam logic [2:0] TYPE_PUSHPULL = 3'h3;
  localparam logic [2:0] TYPE_INV_PUSHPULL = 3'h4;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [26:0] PAIR_CTRL_RST = 27'h0000000;
  localparam logic [4:0] LOCK_MUX_RST = 5'h00;
  localparam logic [2:0] LOCK_TYPE_RST = 3'h3;
  localparam logic [4:0] HOLD_MUX_RST = 5'h06;
  localparam logic [2:0] HOLD_TYPE_RST = 3'h3;
  localparam logic [2:0] IN_MUX_RST = 3'h0;
  localparam logic [2:0] IN_TYPE_RST = 3'h3;
  localparam logic [4:0] RB_ADDR_RST = 5'h00;
  localparam logic RB_LATCH_RST = 1'b0;

  typedef enum logic [2:0]
  {
    RB_IDLE = 3'b001,
    RB_SHIFT = 3'b010,
    RB_DONE = 3'b100
  } scr_rb_state_t;

  // Returns {output enable, level}; readback only through a plain push-pull type
  function automatic logic [1:0] scr_pin_drive(input logic [4:0] mux, input logic [2:0] ptype,
                                               input logic rb_bit, input logic src);
    logic lvl;
    logic drive;
    lvl = 1'b0;
    drive = (ptype == TYPE_PUSHPULL) || (ptype == TYPE_INV_PUSHPULL);
    if (mux == SRC_LOW)
    begin
      lvl = 1'b0;
    end
    else if (mux == SRC_READBACK)
    begin
      lvl = (ptype == TYPE_PUSHPULL) ? rb_bit : 1'b0;
    end
    else
    begin
      lvl = src;
    end
    if ((ptype == TYPE_INV_PUSHPULL) && (mux != SRC_READBACK))
    begin
      lvl = ~lvl;
    end
    return {drive, lvl & drive};
  endfunction : scr_pin_drive

endpackage : scr_pkg

//--- verilog/scr_rb_if.sv
// Carrier between the port controller and the readback shifter.
// Both ends run on the same system clock.
`timescale 1ns/10ps
interface scr_rb_if;
  logic load;
  logic [26:0] word;
  logic step;
  logic active;
  logic bit_q;
  logic valid;

  modport ctrl
  (
    output load,
    output word,
    output step,
    output active,
    input bit_q,
    input valid
  );

  modport shf
  (
    input load,
    input word,
    input step,
    input active,
    output bit_q,
    output valid
  );
endinterface : scr_rb_if

//--- verilog/scr_pin_sync.sv
// Three-stage synchronisers for the serial port pins.
// A new level is accepted only when stages two and three agree.
`timescale 1ns/10ps
module scr_pin_sync
  import scr_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [scr_pkg::PIN_COUNT-1:0] i_pins,
  output logic [scr_pkg::PIN_COUNT-1:0] o_stable
);

  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++)
    begin : g_pin
      logic [2:0] stage;
      always_ff @(posedge i_clock or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          stage <= 3'h0;
        end
        else
        begin
          stage <= {stage[1:0], i_pins[g]};
        end
      end
      always_ff @(posedge i_clock or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          o_stable[g] <= 1'b0;
        end
        else if (stage[1] == stage[2])
        begin
          o_stable[g] <= stage[2];
        end
      end
    end
  endgenerate

endmodule : scr_pin_sync

//--- verilog/scr_readback_shifter.sv
// Shifts a loaded 27-bit register image out one bit per serial clock rise.
// Assumes load and step never fall in the same cycle.
`timescale 1ns/10ps
module scr_readback_shifter
  import scr_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  scr_rb_if.shf rb
);

  scr_rb_state_t state;
  logic [26:0] shreg;
  logic [4:0] count;
  logic [26:0] held_word;
  logic take;

  assign take = rb.step && rb.active;

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state <= RB_IDLE;
      shreg <= 27'h0000000;
      count <= 5'h00;
    end
    else if (rb.load)
    begin
      state <= RB_SHIFT;
      shreg <= {rb.word[25:0], 1'b0};
      count <= 5'h00;
    end
    else if (take)
    begin
      case (state)
        RB_SHIFT:
        begin
          shreg <= {shreg[25:0], 1'b0};
          count <= count + 5'h01;
          if (count == LAST_BIT)
          begin
            state <= RB_DONE;
          end
        end
        RB_DONE: state <= RB_DONE;
        RB_IDLE: state <= RB_IDLE;
        default: state <= RB_IDLE;
      endcase
    end
  end

  // MSB shown at load, one rise ahead
  // Pin path is longer than half a serial period, so each bit is
  // launched one rise early and stands across the following fall
  // Extra clocks give invalid zero
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rb.bit_q <= 1'b0;
      rb.valid <= 1'b0;
    end
    else if (rb.load)
    begin
      rb.bit_q <= rb.word[26];
      rb.valid <= 1'b1;
    end
    else if (take)
    begin
      if ((state == RB_SHIFT) && (count != LAST_BIT))
      begin
        rb.bit_q <= shreg[26];
        rb.valid <= 1'b1;
      end
      else
      begin
        rb.bit_q <= 1'b0;
        rb.valid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      held_word <= 27'h0000000;
    end
    else if (rb.load)
    begin
      held_word <= rb.word;
    end
  end

  first_bit_a:
  assert property (@(posedge i_clock) disable iff (!i_rst_n)
    rb.load |=> rb.bit_q == held_word[LAST_BIT] && rb.valid)
  else $error("readback MSB not shown at load");

  msb_order_a:
  assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (take && state == RB_SHIFT && count != LAST_BIT && !rb.load) |=>
    rb.bit_q == held_word[LAST_BIT - 5'h01 - $past(count)])
  else $error("readback bit out of order");

  read_done_a:
  assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (take && state == RB_SHIFT && count == LAST_BIT && !rb.load) |=>
    state == RB_DONE && !rb.valid && !rb.bit_q)
  else $error("readback not done after 27 clocks");

  extra_invalid_a:
  assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (take && state == RB_DONE && !rb.load) |=> !rb.valid && !rb.bit_q)
  else $error("extra clock produced valid data");

  bit_hold_a:
  assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (!take && !rb.load) |=> $stable(rb.bit_q))
  else $error("readback bit moved between rises");

  read_finished_c: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    take && state == RB_SHIFT && count == LAST_BIT);

  extra_clock_c: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    take && state == RB_DONE);

endmodule : scr_readback_shifter

//--- verilog/scr_serial_config.sv
// Serial configuration port: write capture, register bank and status-pin readback.
// Assumes the serial pins come from the host, asynchronous to i_clock, and
// that the serial clock is several system clocks per phase.
//
// How it works
// - Readback only on plain push-pull readback-selected pins
// - Holdover pin defaults to readback source
// - Each serial rise presents next readback bit
// - Readback uses address written same transaction
// - MSB first, complete after 27 clocks
// - Bits beyond 27 are invalid, ignored
// - Bit valid at serial clock fall
// - Data captured on serial clock rise
// - Read at write address, latch bit elsewhere
// - DAC count is read-only, readback only
// - Reserved bits undefined on readback
// - Readback returns data bits, offset five
// - Soft reset bit restores defaults, ignores rest
`timescale 1ns/10ps
module scr_serial_config
  import scr_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_latch_enable_pin,
  input wire logic i_serial_clock_pin,
  input wire logic i_serial_data_pin,
  input wire logic [scr_pkg::DAC_W-1:0] i_tuning_dac_count,
  input wire logic [scr_pkg::STATUS_PINS-1:0] i_status_src,
  output logic [scr_pkg::STATUS_PINS-1:0] o_status_out,
  output logic [scr_pkg::STATUS_PINS-1:0] o_status_oe,
  output logic [scr_pkg::PAIR_COUNT*scr_pkg::DATA_W-1:0] o_output_pair_ctrl,
  output logic o_read_latch_hold_mode
);
  import scr_pkg::*;

  // ****************************************
  // Pin sampling
  // ****************************************
  logic [2:0] pins_s;
  logic le_s;
  logic sclk_s;
  logic sdata_s;
  logic le_q;
  logic sclk_q;
  logic le_rise;
  logic sclk_rise;

  scr_pin_sync u_sync
  (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_pins({i_serial_data_pin, i_serial_clock_pin, i_latch_enable_pin}),
    .o_stable(pins_s)
  );

  assign le_s = pins_s[0];
  assign sclk_s = pins_s[1];
  assign sdata_s = pins_s[2];

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      le_q <= 1'b0;
      sclk_q <= 1'b0;
    end
    else
    begin
      le_q <= le_s;
      sclk_q <= sclk_s;
    end
  end

  assign le_rise = le_s && !le_q;
  assign sclk_rise = sclk_s && !sclk_q;

  // ****************************************
  // Write capture
  // ****************************************
  logic [31:0] shift_in;
  logic [4:0] wr_addr;
  logic [26:0] wr_data;
  logic soft_rst;

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      shift_in <= 32'h00000000;
    end
    else if (sclk_rise && !le_s)
    begin
      shift_in <= {shift_in[30:0], sdata_s};
    end
  end

  assign wr_addr = shift_in[4:0];
  assign wr_data = shift_in[31:5];
  assign soft_rst = le_rise && (wr_addr == ADDR_PAIR01) && wr_data[SOFT_RESET_POS];

  // ****************************************
  // Register bank
  // ****************************************
  logic [26:0] pair_ctrl [PAIR_COUNT];
  logic [4:0] lock_mux;
  logic [2:0] lock_type;
  logic [4:0] hold_mux;
  logic [2:0] hold_type;
  logic [2:0] in0_mux;
  logic [2:0] in0_type;
  logic [2:0] in1_mux;
  logic [2:0] in1_type;
  logic [4:0] rb_addr;
  logic rb_latch;

  genvar g;
  generate
    for (g = 0; g < PAIR_COUNT; g++)
    begin : g_pair
      always_ff @(posedge i_clock or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          pair_ctrl[g] <= PAIR_CTRL_RST;
        end
        else if (soft_rst)
        begin
          pair_ctrl[g] <= PAIR_CTRL_RST;
        end
        else if (le_rise && (wr_addr == 5'(g)))
        begin
          pair_ctrl[g] <= wr_data;
        end
      end
      assign o_output_pair_ctrl[g*DATA_W +: DATA_W] = pair_ctrl[g];
    end
  endgenerate

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      lock_mux <= LOCK_MUX_RST;
      lock_type <= LOCK_TYPE_RST;
      hold_mux <= HOLD_MUX_RST;
      hold_type <= HOLD_TYPE_RST;
      in0_mux <= IN_MUX_RST;
      in0_type <= IN_TYPE_RST;
      in1_mux <= IN_MUX_RST;
      in1_type <= IN_TYPE_RST;
    end
    else if (soft_rst)
    begin
      lock_mux <= LOCK_MUX_RST;
      lock_type <= LOCK_TYPE_RST;
      hold_mux <= HOLD_MUX_RST;
      hold_type <= HOLD_TYPE_RST;
      in0_mux <= IN_MUX_RST;
      in0_type <= IN_TYPE_RST;
      in1_mux <= IN_MUX_RST;
      in1_type <= IN_TYPE_RST;
    end
    else if (le_rise)
    begin
      case (wr_addr)
        ADDR_PINS_LOCK:
        begin
          lock_mux <= wr_data[LOCK_MUX_POS +: 5];
          lock_type <= wr_data[LOCK_TYPE_POS +: 3];
        end
        ADDR_PINS_HOLD:
        begin
          hold_mux <= wr_data[HOLD_MUX_POS +: 5];
          hold_type <= wr_data[HOLD_TYPE_POS +: 3];
          in1_mux <= wr_data[IN1_MUX_POS +: 3];
          in0_type <= wr_data[IN0_TYPE_POS +: 3];
          in0_mux <= wr_data[IN0_MUX_POS +: 3];
        end
        ADDR_PINS_IN1: in1_type <= wr_data[IN1_TYPE_POS +: 3];
        default: lock_mux <= lock_mux;
      endcase
    end
  end

  // No storage behind the DAC address, writes fall away
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rb_addr <= RB_ADDR_RST;
      rb_latch <= RB_LATCH_RST;
    end
    else if (soft_rst)
    begin
      rb_addr <= RB_ADDR_RST;
      rb_latch <= RB_LATCH_RST;
    end
    else if (le_rise && (wr_addr == ADDR_READBACK))
    begin
      rb_addr <= wr_data[RB_ADDR_POS +: 5];
      rb_latch <= wr_data[RB_LATCH_POS];
    end
  end

  assign o_read_latch_hold_mode = rb_latch;

  // ****************************************
  // Readback image and control
  // ****************************************
  scr_rb_if rb ();
  logic [26:0] next_rb_word;
  logic rb_load;

  // Image per address, latch bit under lock pin setup
  always_comb
  begin
    next_rb_word = 27'h0000000;
    if (rb_addr < 5'(PAIR_COUNT))
    begin
      next_rb_word = pair_ctrl[rb_addr[2:0]];
    end
    else
    begin
      case (rb_addr)
        ADDR_PINS_LOCK:
        begin
          next_rb_word[LOCK_MUX_POS +: 5] = lock_mux;
          next_rb_word[LOCK_TYPE_POS +: 3] = lock_type;
          next_rb_word[LATCH_RD_POS] = rb_latch;
        end
        ADDR_PINS_HOLD:
        begin
          next_rb_word[HOLD_MUX_POS +: 5] = hold_mux;
          next_rb_word[HOLD_TYPE_POS +: 3] = hold_type;
          next_rb_word[IN1_MUX_POS +: 3] = in1_mux;
          next_rb_word[IN0_TYPE_POS +: 3] = in0_type;
          next_rb_word[IN0_MUX_POS +: 3] = in0_mux;
        end
        ADDR_PINS_IN1: next_rb_word[IN1_TYPE_POS +: 3] = in1_type;
        ADDR_DAC: next_rb_word[DAC_POS +: DAC_W] = i_tuning_dac_count;
        ADDR_READBACK: next_rb_word[RB_ADDR_POS +: 5] = rb_addr;
        default: next_rb_word = 27'h0000000;
      endcase
    end
  end

  // Load one cycle after the write lands
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rb_load <= 1'b0;
    end
    else
    begin
      rb_load <= le_rise;
    end
  end

  assign rb.load = rb_load;
  assign rb.word = next_rb_word;
  assign rb.step = sclk_rise;
  // Read phase with LE high in hold mode
  assign rb.active = rb_latch ? le_s : !le_s;

  scr_readback_shifter u_shifter
  (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .rb(rb.shf)
  );

  // ****************************************
  // Status pins
  // ****************************************
  logic [1:0] drv [STATUS_PINS];

  // Readback gated by source and type
  // Registered, steady until next serial rise
  assign drv[0] = scr_pin_drive(lock_mux, lock_type, rb.bit_q, i_status_src[0]);
  assign drv[1] = scr_pin_drive(hold_mux, hold_type, rb.bit_q, i_status_src[1]);
  assign drv[2] = scr_pin_drive({2'h0, in0_mux}, in0_type, rb.bit_q, i_status_src[2]);
  assign drv[3] = scr_pin_drive({2'h0, in1_mux}, in1_type, rb.bit_q, i_status_src[3]);

  generate
    for (g = 0; g < STATUS_PINS; g++)
    begin : g_stat
      always_ff @(posedge i_clock or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          o_status_out[g] <= 1'b0;
          o_status_oe[g] <= 1'b0;
        end
        else
        begin
          o_status_out[g] <= drv[g][0];
          o_status_oe[g] <= drv[g][1];
        end
      end
    end
  endgenerate

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  readback_gate_a:
  assert property ((hold_mux == SRC_READBACK && hold_type != TYPE_PUSHPULL) |=> !o_status_out[1])
  else $error("readback reached pin without push-pull type");

  por_default_a:
  assert property ($rose(i_rst_n) |-> hold_mux == SRC_READBACK && hold_type == TYPE_PUSHPULL)
  else $error("holdover pin not on readback after reset");

  same_txn_a:
  assert property ((le_rise && !soft_rst && wr_addr == ADDR_READBACK) |=>
    rb_load && rb_addr == $past(wr_data[RB_ADDR_POS +: 5]))
  else $error("readback address not used in same transaction");

  capture_a:
  assert property ((sclk_rise && !le_s) |=> shift_in[0] == $past(sdata_s)
    && shift_in[31:1] == $past(shift_in[30:0]))
  else $error("serial data not captured on rise");

  latch_addr_a:
  assert property ((rb_load && (rb_addr == ADDR_PINS_LOCK || rb_addr == ADDR_READBACK)) |->
    rb.word[LATCH_RD_POS] == (rb_latch && rb_addr == ADDR_PINS_LOCK))
  else $error("latch mode bit read at wrong address");

  dac_read_a:
  assert property ((rb_load && rb_addr == ADDR_DAC) |-> rb.word[DAC_POS +: DAC_W] == i_tuning_dac_count)
  else $error("DAC count readback wrong");

  soft_reset_a:
  assert property (soft_rst |=> pair_ctrl[0] == PAIR_CTRL_RST && pair_ctrl[4] == PAIR_CTRL_RST
    && hold_mux == HOLD_MUX_RST && rb_addr == RB_ADDR_RST)
  else $error("soft reset did not restore defaults");

  write_apply_a:
  assert property ((le_rise && !soft_rst && wr_addr == 5'h02) |=> pair_ctrl[2] == $past(wr_data))
  else $error("write word not applied on latch rise");

  soft_reset_c: cover property (soft_rst);
  hold_mode_read_c: cover property (rb_load && rb_latch);
  lock_debug_c: cover property (lock_mux == SRC_LOW && lock_type == TYPE_INV_PUSHPULL);

endmodule : scr_serial_config

//--- tb/scr_host_model.sv
// Host model: drives latch, serial clock and data, samples the readback pin.
// Assumes the readback pin is wired to one selected status pin of the device.
`timescale 1ns/10ps
module scr_host_model #(
  parameter int HALF_NS = 100
)
(
  input wire logic i_rb_pin,
  output logic o_latch_enable_pin,
  output logic o_serial_clock_pin,
  output logic o_serial_data_pin
);
  initial
  begin
    o_latch_enable_pin = 1'b0;
    o_serial_clock_pin = 1'b0;
    o_serial_data_pin = 1'b0;
  end

  // data changes only while clock low
  task automatic put_word(input logic [4:0] addr, input logic [26:0] data);
    logic [31:0] w;
    w = {data, addr};
    for (int i = 31; i >= 0; i--)
    begin
      o_serial_data_pin = w[i];
      #(HALF_NS) o_serial_clock_pin = 1'b1;
      #(HALF_NS) o_serial_clock_pin = 1'b0;
    end
    // Idle data shows the inverse so a stale bit is never mistaken
    o_serial_data_pin = ~w[0];
  endtask : put_word

  // clock already low; hold mode leaves latch high
  task automatic latch(input logic hold);
    #(HALF_NS) o_latch_enable_pin = 1'b1;
    #(HALF_NS) o_latch_enable_pin = hold;
    #(HALF_NS);
  endtask : latch

  // sample at fall, one ignored extra clock, then release
  task automatic read27(output logic [26:0] v);
    for (int i = 26; i >= 0; i--)
    begin
      o_serial_clock_pin = 1'b1;
      #(HALF_NS) o_serial_clock_pin = 1'b0;
      v[i] = i_rb_pin;
      #(HALF_NS);
    end
    o_serial_clock_pin = 1'b1;
    #(HALF_NS) o_serial_clock_pin = 1'b0;
    #(HALF_NS) o_latch_enable_pin = 1'b0;
  endtask : read27
endmodule : scr_host_model

//--- tb/scr_serial_config_test.sv
// Testbench for the serial configuration port: writes, readback, pin setup.
// Assumes the host model above; serial clock period of 200 ns (eight clocks).
`timescale 1ns/10ps
module scr_serial_config_test;
  import scr_pkg::*;
  logic i_clock;
  logic i_rst_n;
  logic [DAC_W-1:0] dac;
  logic [STATUS_PINS-1:0] src;
  logic [STATUS_PINS-1:0] pin_out;
  logic [STATUS_PINS-1:0] pin_oe;
  logic [PAIR_COUNT*DATA_W-1:0] pairs;
  logic hold_mode;
  logic le;
  logic sclk;
  logic sdata;
  logic [1:0] rb_sel;
  logic rb_pin;
  int bad_count;
  int num_checks;

  assign rb_pin = pin_out[rb_sel];

  scr_serial_config dut_u
  (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_latch_enable_pin(le),
    .i_serial_clock_pin(sclk),
    .i_serial_data_pin(sdata),
    .i_tuning_dac_count(dac),
    .i_status_src(src),
    .o_status_out(pin_out),
    .o_status_oe(pin_oe),
    .o_output_pair_ctrl(pairs),
    .o_read_latch_hold_mode(hold_mode)
  );

  // Serial clock period of 200 ns
  scr_host_model #(.HALF_NS(100)) host_u
  (
    .i_rb_pin(rb_pin),
    .o_latch_enable_pin(le),
    .o_serial_clock_pin(sclk),
    .o_serial_data_pin(sdata)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string name, input logic [26:0] exp, input logic [26:0] got);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [4:0] addr, input logic [26:0] data);
    host_u.put_word(addr, data);
    host_u.latch(1'b0);
  endtask : wr

  task automatic rd(input logic [4:0] addr, input logic hold, input logic [26:0] mask,
                    input logic [26:0] exp);
    logic [26:0] v;
    host_u.put_word(ADDR_READBACK, {10'h000, hold, addr, 11'h000});
    host_u.latch(hold);
    if (hold)
      chk("hold mode", 27'h0000001, {26'h0000000, hold_mode});
    host_u.read27(v);
    chk("readback", exp & mask, v & mask);
  endtask : rd

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end

  initial
  begin
    #1000000;
    bad_count++;
    $display("ERROR watchdog expected done seen timeout");
    wrap_up();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    i_rst_n = 1'b0;
    dac = 10'h2A5;
    src = 4'h0;
    rb_sel = 2'h1;
    bad_count = 0;
    num_checks = 0;
    repeat (12) @(posedge i_clock);
    @(negedge i_clock) i_rst_n = 1'b1;
    repeat (6) @(negedge i_clock);
    chk("oe after reset", 27'h000000F, {23'h000000, pin_oe});
    chk("pins after reset", 27'h0000000, {23'h000000, pin_out});
    chk("pairs after reset", 27'h0000000, {26'h0000000, |pairs});
    $display("test reset done");
    wr(5'h03, 27'h5A3C96E);
    chk("pair3 image", 27'h5A3C96E, pairs[3*DATA_W+:DATA_W]);
    rd(5'h03, 1'b0, 27'h7FFEFFF, 27'h5A3C96E);
    wr(5'h02, 27'h1234567);
    rd(5'h02, 1'b0, 27'h5FFEFFF, 27'h1234567);
    chk("pair3 kept", 27'h5A3C96E, pairs[3*DATA_W+:DATA_W]);
    $display("test write readback done");
    wr(ADDR_DAC, 27'h7FFFFFF);
    rd(ADDR_DAC, 1'b0, 27'h00003FF, 27'h00002A5);
    $display("test read only done");
    rd(ADDR_PINS_LOCK, 1'b1, 27'h7F90000, 27'h0190000);
    $display("test hold mode done");
    wr(ADDR_PINS_LOCK, 27'h0200000);
    chk("lock pin inverted", 27'h0000001, {26'h0000000, pin_out[0]});
    src = 4'h1;
    wr(ADDR_PINS_LOCK, 27'h0580000);
    chk("lock pin source", 27'h0000001, {26'h0000000, pin_out[0]});
    wr(ADDR_PINS_LOCK, 27'h0180000);
    chk("lock pin plain", 27'h0000000, {26'h0000000, pin_out[0]});
    $display("test debug toggle done");
    wr(5'h04, 27'h2A5A5A5);
    wr(ADDR_PINS_HOLD, 27'h1A01800);
    wr(ADDR_PINS_LOCK, 27'h1980000);
    rb_sel = 2'h0;
    rd(5'h04, 1'b0, 27'h7FFEFFF, 27'h2A5A5A5);
    chk("holdover blanked", 27'h0000002, {25'h0000000, pin_oe[1], pin_out[1]});
    $display("test pin select done");
    wr(ADDR_PAIR01, 27'h7FFFFFF);
    chk("pairs after soft reset", 27'h0000000, {26'h0000000, |pairs});
    chk("hold after soft reset", 27'h0000000, {26'h0000000, hold_mode});
    chk("lock pin after soft reset", 27'h0000000, {26'h0000000, pin_out[0]});
    $display("test soft reset done");
    wrap_up();
  end
endmodule : scr_serial_config_test
